// >>> verilog/pccr_pkg.sv
`default_nettype none
package pccr_pkg;
  localparam logic [7:0] PCCR_ADDR_CLKOUT = 8'h1b;
  localparam logic [7:0] PCCR_ADDR_CODING = 8'h1c;
  localparam logic [7:0] PCCR_ADDR_NODE = 8'h1d;
  localparam logic [7:0] PCCR_ADDR_FORMAT = 8'h1e;
  localparam logic [7:0] PCCR_ADDR_PAGE = 8'h1f;
  localparam logic [7:0] PCCR_ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] PCCR_ADDR_IRQ_MASK = 8'h21;
  localparam logic [7:0] PCCR_RST_CLKOUT = 8'hbc;
  localparam logic [7:0] PCCR_RST_CODING = 8'h00;
  localparam logic [7:0] PCCR_RST_NODE = 8'h00;
  localparam logic [7:0] PCCR_RST_FORMAT = 8'h40;
  localparam logic [7:0] PCCR_RST_PAGE = 8'h00;
  localparam logic [7:0] PCCR_MASK_CLKOUT = 8'hfc;
  localparam logic [7:0] PCCR_MASK_FORMAT_RW = 8'hfe;
  localparam logic [7:0] PCCR_MASK_PAGE = 8'hc3;
  localparam int PCCR_BIT_EN = 7;
  localparam int PCCR_BIT_SCRAMBLE = 4;
  localparam int PCCR_BIT_CRC_EN = 3;
  localparam int PCCR_BIT_CRC_STAT = 0;
  localparam int PCCR_BIT_DIR = 6;
  localparam logic [7:0] PCCR_ADDR_ZERO = 8'h00;
  localparam logic [7:0] PCCR_ADDR_ALL = 8'hff;
  localparam logic [1:0] PCCR_CMP_NONE = 2'h0;
  localparam logic [1:0] PCCR_CMP_NODE = 2'h1;
  localparam logic [1:0] PCCR_CMP_ZERO = 2'h2;
  localparam int PCCR_NIRQ = 3;
  typedef struct packed {
    logic manchester_en;
    logic [6:0] packet_len;
    logic [7:0] node_addr;
    logic variable_len;
    logic [1:0] preamble_code;
    logic scramble_en;
    logic crc_en;
    logic [1:0] addr_cmp;
    logic fifo_autoclear_control;
    logic fifo_direction_select;
    logic [1:0] page_sel;
  } pccr_cfg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pccr_bus_t;
endpackage
`default_nettype wire

// >>> verilog/pccr_clkdiv.sv
`default_nettype none
module pccr_clkdiv
  import pccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [4:0] divider,
  output logic clk_out
);
  typedef struct packed {
    logic [4:0] cnt;
    logic lvl;
  } pccr_div_t;
  pccr_div_t s_r;
  pccr_div_t s_nxt;
  // Half period is M crystal cycles; M of zero passes the crystal through undivided.
  always_comb begin
    s_nxt = s_r;
    if (!enable) begin
      s_nxt.cnt = 5'h00;
      s_nxt.lvl = 1'b0;
    end else if (divider == 5'h00) begin
      s_nxt.cnt = 5'h00;
    end else if (s_r.cnt >= divider - 5'h01) begin
      s_nxt.cnt = 5'h00;
      s_nxt.lvl = ~s_r.lvl;
    end else begin
      s_nxt.cnt = s_r.cnt + 5'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Undivided mode gates the system clock itself, so it is glitch-prone if M changes live.
  assign clk_out = enable && (divider == 5'h00) ? clk_sys : s_r.lvl;
endmodule
`default_nettype wire

// >>> verilog/pccr_addr_filter.sv
`default_nettype none
module pccr_addr_filter
  import pccr_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic [7:0] node_addr,
  input wire logic [7:0] rx_addr,
  output logic accept
);
  always_comb begin
    unique case (mode)
      PCCR_CMP_NONE: accept = 1'b1;
      PCCR_CMP_NODE: accept = rx_addr == node_addr;
      PCCR_CMP_ZERO: accept = rx_addr == node_addr || rx_addr == PCCR_ADDR_ZERO;
      default: accept = rx_addr == node_addr || rx_addr == PCCR_ADDR_ZERO
                        || rx_addr == PCCR_ADDR_ALL;
    endcase
  end
endmodule
`default_nettype wire

// >>> verilog/pccr_regs.sv
`default_nettype none
module pccr_regs
  import pccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr,
  input wire logic crc_done,
  input wire logic crc_ok,
  input wire logic standby,
  output logic rx_addr_accept,
  output logic fifo_clear,
  output logic fifo_sel_read,
  output logic [2:0] preamble_bytes,
  output pccr_cfg_t cfg,
  output logic clkout_pin,
  output logic clkout_oe,
  output logic irq
);
  typedef struct packed {
    logic [7:0] osc;
    pccr_cfg_t cfg;
    logic crc_stat;
    logic [PCCR_NIRQ-1:0] irq_stat;
    logic [PCCR_NIRQ-1:0] irq_mask;
    logic [7:0] rdata;
    logic accept;
    logic fifo_clear;
    logic fifo_sel_read;
    logic [2:0] pre_bytes;
    logic irq;
    logic clk_oe;
  } pccr_state_t;
  pccr_state_t s_r;
  pccr_state_t s_nxt;
  logic filt_accept;
  logic div_clk;
  logic [PCCR_NIRQ-1:0] ev;
  pccr_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  pccr_addr_filter u_filt (
    .mode(s_r.cfg.addr_cmp),
    .node_addr(s_r.cfg.node_addr),
    .rx_addr(rx_addr),
    .accept(filt_accept)
  );

  pccr_clkdiv u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(s_r.osc[PCCR_BIT_EN]),
    .divider(s_r.osc[6:2]),
    .clk_out(div_clk)
  );

  // Events: CRC pass, CRC fail, accepted address.
  assign ev = {rx_addr_valid && filt_accept,
               crc_done && s_r.cfg.crc_en && !crc_ok,
               crc_done && s_r.cfg.crc_en && crc_ok};

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.fifo_clear = 1'b0;
    s_nxt.accept = rx_addr_valid && filt_accept;
    if (bus.wr) begin
      unique case (bus.addr)
        PCCR_ADDR_CLKOUT: s_nxt.osc = bus.wdata & PCCR_MASK_CLKOUT;
        PCCR_ADDR_CODING: begin
          s_nxt.cfg.manchester_en = bus.wdata[PCCR_BIT_EN];
          s_nxt.cfg.packet_len = bus.wdata[6:0];
        end
        PCCR_ADDR_NODE: s_nxt.cfg.node_addr = bus.wdata;
        PCCR_ADDR_FORMAT: begin
          s_nxt.cfg.variable_len = bus.wdata[PCCR_BIT_EN];
          s_nxt.cfg.preamble_code = bus.wdata[6:5];
          s_nxt.cfg.scramble_en = bus.wdata[PCCR_BIT_SCRAMBLE];
          s_nxt.cfg.crc_en = bus.wdata[PCCR_BIT_CRC_EN];
          s_nxt.cfg.addr_cmp = bus.wdata[2:1];
          if (bus.wdata[PCCR_BIT_CRC_STAT]) begin
            s_nxt.crc_stat = 1'b0;
          end
        end
        PCCR_ADDR_PAGE: begin
          s_nxt.cfg.fifo_autoclear_control = bus.wdata[PCCR_BIT_EN];
          s_nxt.cfg.fifo_direction_select = bus.wdata[PCCR_BIT_DIR];
          // Other page codes are stored as written; software keeps them at zero.
          s_nxt.cfg.page_sel = bus.wdata[1:0];
        end
        PCCR_ADDR_IRQ_MASK: s_nxt.irq_mask = bus.wdata[PCCR_NIRQ-1:0];
        default: begin
        end
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        PCCR_ADDR_CLKOUT: s_nxt.rdata = s_r.osc;
        PCCR_ADDR_CODING: s_nxt.rdata = {s_r.cfg.manchester_en, s_r.cfg.packet_len};
        PCCR_ADDR_NODE: s_nxt.rdata = s_r.cfg.node_addr;
        PCCR_ADDR_FORMAT: s_nxt.rdata = {s_r.cfg.variable_len, s_r.cfg.preamble_code,
                                         s_r.cfg.scramble_en, s_r.cfg.crc_en,
                                         s_r.cfg.addr_cmp, s_r.crc_stat};
        PCCR_ADDR_PAGE: s_nxt.rdata = {s_r.cfg.fifo_autoclear_control,
                                       s_r.cfg.fifo_direction_select, 4'h0,
                                       s_r.cfg.page_sel};
        PCCR_ADDR_IRQ_STAT: begin
          s_nxt.rdata = {5'h00, s_r.irq_stat};
          s_nxt.irq_stat = '0;
        end
        PCCR_ADDR_IRQ_MASK: s_nxt.rdata = {5'h00, s_r.irq_mask};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // A result arriving with the clearing write still lands, so no outcome is lost.
    if (crc_done && s_r.cfg.crc_en) begin
      s_nxt.crc_stat = crc_ok;
      s_nxt.fifo_clear = !crc_ok && !s_r.cfg.fifo_autoclear_control;
    end
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    s_nxt.fifo_sel_read = standby && s_nxt.cfg.fifo_direction_select;
    s_nxt.pre_bytes = {1'b0, s_nxt.cfg.preamble_code} + 3'h1;
    s_nxt.clk_oe = s_nxt.osc[PCCR_BIT_EN];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.osc <= PCCR_RST_CLKOUT;
      s_r.cfg <= pccr_cfg_t'({PCCR_RST_CODING, PCCR_RST_NODE,
                              PCCR_RST_FORMAT[7:1], PCCR_RST_PAGE[7:6],
                              PCCR_RST_PAGE[1:0]});
      s_r.pre_bytes <= 3'h3;
      s_r.clk_oe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign rx_addr_accept = s_r.accept;
  assign fifo_clear = s_r.fifo_clear;
  assign fifo_sel_read = s_r.fifo_sel_read;
  assign preamble_bytes = s_r.pre_bytes;
  assign cfg = s_r.cfg;
  assign irq = s_r.irq;
  assign clkout_oe = s_r.clk_oe;
  // The divided clock is itself a flop; the undivided pass-through cannot be registered.
  assign clkout_pin = s_r.clk_oe ? div_clk : 1'b0;
endmodule
`default_nettype wire

// >>> verilog/empty_placeholder_none.sv
`default_nettype none
`default_nettype wire

// >>> tb/pccr_regs_props.sv
`default_nettype none
module pccr_regs_props
  import pccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_addr_valid,
  input wire logic crc_done,
  input wire logic crc_ok,
  input wire logic standby,
  input wire logic rx_addr_accept,
  input wire logic fifo_clear,
  input wire logic fifo_sel_read,
  input wire logic [2:0] preamble_bytes,
  input wire pccr_cfg_t cfg,
  input wire logic clkout_pin,
  input wire logic clkout_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_pin_quiet: assert property (!clkout_oe |-> !clkout_pin)
    else $error("clock pin moves while disabled");
  chk_preamble_len: assert property (preamble_bytes == {1'b0, cfg.preamble_code} + 3'h1)
    else $error("preamble length wrong");
  chk_fifo_clear: assert property (crc_done && !crc_ok && cfg.crc_en
    && !cfg.fifo_autoclear_control |=> fifo_clear)
    else $error("fifo not cleared");
  chk_fifo_cause: assert property (fifo_clear |-> $past(crc_done && !crc_ok))
    else $error("fifo cleared without failure");
  chk_dir_idle: assert property (!standby |=> !fifo_sel_read)
    else $error("read fifo selected outside standby");
  chk_dir_read: assert property ((standby && cfg.fifo_direction_select)[*2] |-> fifo_sel_read)
    else $error("read fifo not selected");
  chk_accept_cause: assert property (rx_addr_accept |-> $past(rx_addr_valid))
    else $error("accept without address");
  chk_accept_open: assert property (rx_addr_valid && cfg.addr_cmp == PCCR_CMP_NONE
    |=> rx_addr_accept)
    else $error("address refused without compare");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > PCCR_ADDR_IRQ_MASK
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cov_clear: cover property (fifo_clear);
  cov_accept: cover property (rx_addr_accept);
  cov_dir: cover property (fifo_sel_read);
endmodule
`default_nettype wire

// >>> tb/pccr_host.sv
`default_nettype none
module pccr_host
  import pccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output var pccr_bus_t bus
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  // Read data is only valid in the one cycle after the strobe, so it is taken there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_packet_and_clock_out_config_regs.sv
`default_nettype none
module test_packet_and_clock_out_config_regs
  import pccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic rx_addr_valid = 1'b0, crc_done = 1'b0, crc_ok = 1'b0, standby = 1'b0, prv;
  logic [7:0] rx_addr = 8'h00, rd_v, reg_rdata;
  logic rx_addr_accept, fifo_clear, fifo_sel_read, clkout_pin, clkout_oe, irq;
  logic [2:0] preamble_bytes;
  logic [15:0] lfsr = 16'h0013;
  pccr_cfg_t cfg;
  pccr_bus_t bus;
  int err_total = 0, cmp_count = 0, cyc = 0, ch, mdl[5], ex;
  localparam logic [7:0] MSK [5] = '{8'hfc, 8'hff, 8'hff, 8'hfe, 8'hc3};
  localparam logic [7:0] ADR [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
  always #2 clk_sys = ~clk_sys;
  pccr_host host(.clk_sys(clk_sys), .reg_rdata(reg_rdata), .bus(bus));
  pccr_regs dut(.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(bus.addr), .reg_wdata(bus.wdata),
    .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(reg_rdata), .rx_addr_valid(rx_addr_valid),
    .rx_addr(rx_addr), .crc_done(crc_done), .crc_ok(crc_ok), .standby(standby),
    .rx_addr_accept(rx_addr_accept), .fifo_clear(fifo_clear), .fifo_sel_read(fifo_sel_read),
    .preamble_bytes(preamble_bytes), .cfg(cfg), .clkout_pin(clkout_pin),
    .clkout_oe(clkout_oe), .irq(irq));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Registered pulses are looked at in the cycle right after the event edge.
  task automatic ev(input logic d, input logic ok, input logic v, input logic [7:0] a);
    @(posedge clk_sys);
    crc_done <= d;
    crc_ok <= ok;
    rx_addr_valid <= v;
    rx_addr <= a;
    @(posedge clk_sys);
    crc_done <= 1'b0;
    rx_addr_valid <= 1'b0;
    #1;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    mdl = '{8'hbc, 8'h00, 8'h00, 8'h40, 8'h00};
    for (int i = 0; i < 5; i++) begin
      host.rd(PCCR_ADDR_CLKOUT + 8'(i), rd_v);
      chk("reset", rd_v, mdl[i]);
      lfsr = nxt(lfsr);
      rd_v = (i == 4) ? (lfsr[7:0] & 8'hfc) : lfsr[7:0];
      mdl[i] = rd_v & MSK[i];
      host.wr(PCCR_ADDR_CLKOUT + 8'(i), rd_v);
    end
    for (int i = 0; i < 5; i++) begin
      host.rd(PCCR_ADDR_CLKOUT + 8'(i), rd_v);
      chk("readback", rd_v, mdl[i]);
    end
    chk("cfg", cfg, {mdl[1][7:0], mdl[2][7:0], mdl[3][7:1], mdl[4][7:6], mdl[4][1:0]});
    chk("preamble", preamble_bytes, mdl[3][6:5] + 1);
    chk("oe", clkout_oe, mdl[0][7]);
    host.rd(8'h30, rd_v);
    chk("unmapped", rd_v, 0);
    $display("registers done");
    host.wr(PCCR_ADDR_CLKOUT, 8'h8c);
    repeat (8) @(posedge clk_sys);
    #1 prv = clkout_pin;
    ch = 0;
    repeat (12) begin
      @(posedge clk_sys);
      #1 ch += int'(clkout_pin != prv);
      prv = clkout_pin;
    end
    chk("divider", ch, 4);
    host.wr(PCCR_ADDR_CLKOUT, 8'h0c);
    repeat (3) @(posedge clk_sys);
    repeat (4) begin
      @(posedge clk_sys);
      #1 chk("pin off", {clkout_pin, clkout_oe}, 0);
    end
    $display("clock done");
    host.wr(PCCR_ADDR_FORMAT, 8'h08);
    host.wr(PCCR_ADDR_PAGE, 8'h00);
    host.wr(PCCR_ADDR_IRQ_MASK, 8'h02);
    ev(1'b1, 1'b1, 1'b0, 8'h00);
    chk("masked irq", irq, 0);
    host.wr(PCCR_ADDR_FORMAT, 8'h08);
    host.rd(PCCR_ADDR_FORMAT, rd_v);
    chk("crc pass", rd_v, 8'h09);
    host.wr(PCCR_ADDR_FORMAT, 8'h09);
    host.rd(PCCR_ADDR_FORMAT, rd_v);
    chk("crc clear", rd_v, 8'h08);
    ev(1'b1, 1'b0, 1'b0, 8'h00);
    chk("fifo clear", {fifo_clear, irq}, 2'b11);
    host.rd(PCCR_ADDR_IRQ_STAT, rd_v);
    chk("irq stat", {rd_v, irq}, 9'h006);
    host.wr(PCCR_ADDR_PAGE, 8'h80);
    ev(1'b1, 1'b0, 1'b0, 8'h00);
    chk("fifo kept", fifo_clear, 0);
    host.wr(PCCR_ADDR_PAGE, 8'h40);
    @(posedge clk_sys);
    standby <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("dir", fifo_sel_read, 1);
    @(posedge clk_sys);
    standby <= 1'b0;
    $display("crc done");
    host.wr(PCCR_ADDR_NODE, ADR[0]);
    for (int m = 0; m < 4; m++) begin
      host.wr(PCCR_ADDR_FORMAT, 8'(m * 2));
      for (int k = 0; k < 4; k++) begin
        ev(1'b0, 1'b0, 1'b1, ADR[k]);
        ex = (m == 0 || k == 0 || (m > 1 && k == 1) || (m == 3 && k == 2)) ? 1 : 0;
        chk("filter", rx_addr_accept, ex);
      end
    end
    $display("filter done");
    test_done();
  end
endmodule
bind pccr_regs pccr_regs_props props(.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_addr_valid(rx_addr_valid), .crc_done(crc_done),
  .crc_ok(crc_ok), .standby(standby), .rx_addr_accept(rx_addr_accept),
  .fifo_clear(fifo_clear), .fifo_sel_read(fifo_sel_read), .preamble_bytes(preamble_bytes),
  .cfg(cfg), .clkout_pin(clkout_pin), .clkout_oe(clkout_oe));
`default_nettype wire
